// ==== dv/crf_top_assertions.sv ====
/*
  crf_top_assertions: bus answer and register state checks on crf_top.
  assumes: bound to crf_top, single-cycle wishbone master, one clock.
*/
`timescale 1ns/1ps
module crf_top_assertions #(
  parameter int DPORT_BITS = 12
) (
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  // wishbone slave
  input wire logic                  cyc_i,
  input wire logic                  stb_i,
  input wire logic                  we_i,
  input wire logic [7:0]            adr_i,
  input wire logic [3:0]            sel_i,
  input wire logic [31:0]           dat_i,
  input wire logic [31:0]           dat_o,
  input wire logic                  ack_o,
  input wire logic                  err_o,
  // core view
  input wire logic [13:0]           icnt_o,
  input wire logic [9:0]            sp_o,
  input wire logic [9:0]            ram_addr_o,
  input wire logic [DPORT_BITS-1:0] dport_sel_o,
  input wire logic                  branch_taken_o,
  input wire logic                  intr_enable_o,
  input wire logic                  intr_mask_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic mapped;
  logic ev_wr;
  assign take   = cyc_i && stb_i && !ack_o && !err_o;
  assign mapped = adr_i[1:0] == 2'b00 && adr_i <= 8'h9C;
  assign ev_wr  = take && we_i && adr_i == crf_pkg::OFS_EVENT
                  && sel_i[1:0] == 2'b11;

  chk_ack_mapped: assert property (take && mapped |=> ack_o && !err_o)
    else $error("mapped access not acknowledged");
  chk_err_unmapped: assert property (take && !mapped |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  chk_reset_state: assert property (disable iff (1'b0) rst_i |=>
    icnt_o == 14'h0000 && sp_o == 10'h3FF && branch_taken_o
    && !intr_enable_o && intr_mask_o) else $error("reset state wrong");
  chk_sp_top_fixed: assert property (sp_o[9:6] == 4'hF && sp_o[1:0] == 2'b11)
    else $error("stack pointer fixed bits lost");
  chk_sp_push_step: assert property (ev_wr && dat_i[13:0] == 14'h0040 |=>
    sp_o[5:0] == $past(sp_o[5:0]) - 6'd4) else $error("push step wrong");
  chk_sp_pop_step: assert property (ev_wr && dat_i[13:0] == 14'h0080 |=>
    sp_o[5:0] == $past(sp_o[5:0]) + 6'd4) else $error("pop step wrong");
  chk_branch_fetch: assert property (ev_wr && dat_i[2] |=> branch_taken_o)
    else $error("branch fetch did not set flag");
  chk_branch_hold: assert property ($changed(branch_taken_o) |-> $past(ev_wr))
    else $error("branch flag changed without cause");
  chk_dport_row: assert property (ram_addr_o[7:4] < 4'd12 |->
    $onehot(dport_sel_o) && dport_sel_o[ram_addr_o[7:4]])
    else $error("d-port select does not follow row index");

  cover property (ev_wr && dat_i[13:0] == 14'h0040);
  cover property (ev_wr && dat_i[13:0] == 14'h0010);
  cover property (take && !mapped);
endmodule : crf_top_assertions

bind crf_top crf_top_assertions #(.DPORT_BITS(DPORT_BITS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .icnt_o(icnt_o), .sp_o(sp_o), .ram_addr_o(ram_addr_o),
  .dport_sel_o(dport_sel_o), .branch_taken_o(branch_taken_o),
  .intr_enable_o(intr_enable_o), .intr_mask_o(intr_mask_o));

// ==== dv/crf_top_test.sv ====
/*
  crf_top_test: directed wishbone bench for crf_top.
  assumes: the design answers each access one cycle after taking it.
*/
`timescale 1ns/1ps
module crf_top_test;
  logic        clk_i = 1'b0;
  logic        rst_i, cyc_i, stb_i, we_i, ack_o, err_o, e;
  logic        branch_taken_o, intr_enable_o, intr_mask_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [13:0] icnt_o;
  logic [9:0]  sp_o, ram_addr_o;
  logic [11:0] dport_sel_o;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  crf_top #(.DPORT_BITS(12)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .icnt_o(icnt_o), .sp_o(sp_o), .ram_addr_o(ram_addr_o),
    .dport_sel_o(dport_sel_o), .branch_taken_o(branch_taken_o),
    .intr_enable_o(intr_enable_o), .intr_mask_o(intr_mask_o));

  always #5 clk_i = ~clk_i;

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // ceiling is several times the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      $display("CHECK FAILED t=%0t run did not finish", $time);
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check

  // entered just after a rising edge; returns one idle cycle after the answer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 16);
    q = dat_o;
    e = err_o;
    if (n >= 16) check(32'd0, 32'd1, "no bus answer");
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    check({31'd0, e}, 32'd0, "write refused");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m);
    bus(1'b0, a, 32'h0000_0000);
    check(q & m, x, "read data");
  endtask : rd

  task automatic ev(input int b);
    wr(crf_pkg::OFS_EVENT, 32'h0000_0001 << b);
  endtask : ev

  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hF;
    dat_i = 32'h0000_0000;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    check({18'd0, icnt_o}, 32'h0000_0000, "icnt reset");
    check({22'd0, sp_o}, 32'h0000_03FF, "sp reset");
    check({branch_taken_o, intr_enable_o, intr_mask_o}, 3'b101, "ctl");
    rd(crf_pkg::OFS_INTCTL, 32'h0000_0004, 32'h0000_0007);
    rd(crf_pkg::OFS_FLAGS, 32'h0000_0002, 32'h0000_0002);
    for (int i = 12; i <= 23; i++)
      rd(8'(4 * i), 32'h0, i == 14 ? 32'hB : 32'hFFFF_FFFF);
    for (int i = 24; i <= 39; i++)
      rd(8'(4 * i), 32'h0000_000F, 32'hFFFF_FFFF);
    $display("test reset values done");
    // upper bits must read zero: page is two bits, the rest four
    for (int i = 0; i <= 6; i++) begin
      wr(8'(4 * i), 32'hFFFF_FFF0 | 32'(i + 9));
      rd(8'(4 * i), 32'(i + 9) & (i == 2 ? 32'h3 : 32'hF), 32'hFFFF_FFFF);
    end
    wr(crf_pkg::OFS_PAGE, 32'h2);
    wr(crf_pkg::OFS_ROW, 32'h5);
    wr(crf_pkg::OFS_COL, 32'h9);
    check({22'd0, ram_addr_o}, 32'h0000_0259, "ram address");
    check({20'd0, dport_sel_o}, 32'h0000_0020, "dport row 5");
    wr(crf_pkg::OFS_ROW, 32'hB);
    check({20'd0, dport_sel_o}, 32'h0000_0800, "dport row 11");
    wr(crf_pkg::OFS_ICNT, 32'hFFFF_FFFF);
    rd(crf_pkg::OFS_ICNT, 32'h0000_3FFF, 32'hFFFF_FFFF);
    check({18'd0, icnt_o}, 32'h0000_3FFF, "icnt port");
    bus(1'b1, crf_pkg::OFS_SP, 32'h0);
    rd(crf_pkg::OFS_SP, 32'h0000_03FF, 32'hFFFF_FFFF);
    wr(8'h60, 32'h0000_00A5);
    rd(8'h60, 32'h0000_00A5, 32'hFFFF_FFFF);
    wr(8'h9C, 32'h0000_003C);
    rd(8'h9C, 32'h0000_003C, 32'hFFFF_FFFF);
    rd(8'h64, 32'h0000_000F, 32'hFFFF_FFFF);
    $display("test working registers done");
    for (int i = 1; i <= 16; i++) begin
      ev(crf_pkg::EV_PUSH);
      check({22'd0, sp_o}, {22'd0, 4'hF, 6'h3F - 6'(4 * i)}, "push");
    end
    for (int i = 1; i <= 16; i++) begin
      ev(crf_pkg::EV_POP);
      check({22'd0, sp_o}, {22'd0, 4'hF, 6'h3F + 6'(4 * i)}, "pop");
    end
    ev(crf_pkg::EV_PUSH);
    wr(crf_pkg::OFS_INTCTL, 32'hC);
    wr(crf_pkg::OFS_INTCTL, 32'h4);
    check({22'd0, sp_o}, 32'h0000_03FF, "reinit reload");
    ev(crf_pkg::EV_PUSH);
    ev(crf_pkg::EV_SPINIT);
    check({22'd0, sp_o}, 32'h0000_03FF, "event reload");
    $display("test stack pointer done");
    wr(crf_pkg::OFS_EVENT, 32'h0000_0003);
    rd(crf_pkg::OFS_FLAGS, 32'h1, 32'h1);
    wr(crf_pkg::OFS_EVENT, 32'h0000_0400);
    rd(crf_pkg::OFS_FLAGS, 32'h0, 32'h1);
    wr(crf_pkg::OFS_EVENT, 32'h0000_1400);
    rd(crf_pkg::OFS_FLAGS, 32'h1, 32'h1);
    ev(crf_pkg::EV_SETC);
    rd(crf_pkg::OFS_FLAGS, 32'h1, 32'h1);
    ev(crf_pkg::EV_CLRC);
    rd(crf_pkg::OFS_FLAGS, 32'h0, 32'h1);
    ev(crf_pkg::EV_SETC);
    wr(crf_pkg::OFS_EVENT, 32'h0000_2000);
    check({31'd0, branch_taken_o}, 32'h0, "branch latch");
    ev(crf_pkg::EV_IENTRY);
    check({22'd0, sp_o}, 32'h0000_03FB, "entry push");
    ev(crf_pkg::EV_CLRC);
    ev(crf_pkg::EV_BRFET);
    check({31'd0, branch_taken_o}, 32'h1, "branch fetch");
    ev(crf_pkg::EV_IRET);
    rd(crf_pkg::OFS_FLAGS, 32'h1, 32'h3);
    ev(crf_pkg::EV_IENTRY);
    ev(crf_pkg::EV_CLRC);
    ev(crf_pkg::EV_BRFET);
    ev(crf_pkg::EV_SRET);
    rd(crf_pkg::OFS_FLAGS, 32'h2, 32'h3);
    check({22'd0, sp_o}, 32'h0000_03FF, "return pop");
    $display("test flags done");
    bus(1'b0, 8'hA0, 32'h0);
    check({31'd0, e}, 32'h1, "unmapped read");
    bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
    check({31'd0, e}, 32'h1, "unmapped write");
    rd(crf_pkg::OFS_EVENT, 32'h0, 32'hFFFF_FFFF);
    ev(crf_pkg::EV_PUSH);
    wr(crf_pkg::OFS_EVENT, 32'h0000_2000);
    wr(crf_pkg::OFS_INTCTL, 32'h1);
    check({intr_enable_o, intr_mask_o}, 2'b10, "interrupt control");
    // shortest reset the system may give while running
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check({22'd0, sp_o}, 32'h0000_03FF, "sp second reset");
    check({branch_taken_o, intr_enable_o, intr_mask_o}, 3'b101, "ctl2");
    check({18'd0, icnt_o}, 32'h0, "icnt second reset");
    rd(crf_pkg::OFS_INTCTL, 32'h0000_0004, 32'h0000_0007);
    rd(8'h60, 32'h0000_000F, 32'hFFFF_FFFF);
    $display("test bus and second reset done");
    complete_run();
  end
endmodule : crf_top_test

// ==== hdl/crf_pkg.sv ====
/*
  crf_pkg: constants, register offsets, reset values and carrier structs
  for the cpu register and flag file.
  assumes: used by crf_top and by the dv bench and checker, every reference scoped crf_pkg::name.
*/
package crf_pkg;

  // wishbone word offsets (byte addresses)
  localparam logic [7:0] OFS_ACC      = 8'h00;
  localparam logic [7:0] OFS_OPB      = 8'h04;
  localparam logic [7:0] OFS_PAGE     = 8'h08;
  localparam logic [7:0] OFS_COL      = 8'h0C;
  localparam logic [7:0] OFS_ROW      = 8'h10;
  localparam logic [7:0] OFS_AUXX     = 8'h14;
  localparam logic [7:0] OFS_AUXY     = 8'h18;
  localparam logic [7:0] OFS_FLAGS    = 8'h1C;
  localparam logic [7:0] OFS_ICNT     = 8'h20;
  localparam logic [7:0] OFS_SP       = 8'h24;
  localparam logic [7:0] OFS_EVENT    = 8'h28;
  localparam logic [7:0] OFS_INTCTL   = 8'h2C;
  localparam logic [7:0] OFS_PFSA     = 8'h30;
  localparam logic [7:0] OFS_PFSB     = 8'h34;
  localparam logic [7:0] OFS_PFSC     = 8'h38;
  localparam logic [7:0] OFS_EDGE1    = 8'h3C;
  localparam logic [7:0] OFS_EDGE2    = 8'h40;
  localparam logic [7:0] OFS_TMRA     = 8'h44;
  localparam logic [7:0] OFS_TMRB1    = 8'h48;
  localparam logic [7:0] OFS_TMRB2    = 8'h4C;
  localparam logic [7:0] OFS_TMRC1    = 8'h50;
  localparam logic [7:0] OFS_TMRC2    = 8'h54;
  localparam logic [7:0] OFS_TMRD1    = 8'h58;
  localparam logic [7:0] OFS_TMRD2    = 8'h5C;
  localparam logic [7:0] OFS_DRAM     = 8'h60;

  // event register bit positions (write 1 to fire, reads as zero)
  localparam int EV_ARITH  = 0;
  localparam int EV_FLAG   = 1;
  localparam int EV_BRFET  = 2;
  localparam int EV_IENTRY = 3;
  localparam int EV_IRET   = 4;
  localparam int EV_SRET   = 5;
  localparam int EV_PUSH   = 6;
  localparam int EV_POP    = 7;
  localparam int EV_SETC   = 8;
  localparam int EV_CLRC   = 9;
  localparam int EV_ROTC   = 10;
  localparam int EV_SPINIT = 11;
  localparam int EV_ROTV   = 12;
  localparam int EV_RESV   = 13;

  // flags register fields
  localparam int FL_OVF = 0;
  localparam int FL_BCF = 1;

  // reset values, stack and port sizes
  localparam logic [13:0] ICNT_RST   = 14'h0000;
  localparam logic [9:0]  SP_RST     = 10'h3FF;
  localparam logic [3:0]  SP_TOP     = 4'hF;
  localparam logic [9:0]  SP_STEP    = 10'h004;
  localparam logic [3:0]  NIB_ZERO   = 4'h0;
  localparam logic [3:0]  NIB_ONES   = 4'hF;
  localparam int          DIR_REGS   = 16;
  localparam int          STACK_LVLS = 16;

  // one decoded bus access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] adr;
    logic [31:0] dat;
  } crf_req_type;

  // flag pair saved on interrupt entry
  typedef struct packed {
    logic ovf;
    logic bcf;
  } crf_flags_type;

endpackage : crf_pkg

// ==== hdl/crf_top.sv ====
/*
  crf_top: cpu register and flag file with its reset state, reached over
  a classic wishbone slave; software stands in for the core sequencer by
  writing operands and firing events through the event register.
  assumes: one 100 MHz clock, synchronous active-high reset held at least
  two instruction cycles by the system, single-cycle wishbone master.
*/
// Functional notes
// - accumulator and second operand register, four bits each, fully writable
// - two-bit page, four-bit column and row indices form indirect address
// - row index also selects the addressed d-port bit
// - two four-bit auxiliary registers beside column and row indices
// - overflow bit takes alu overflow; set, clear and rotate ops change it
// - overflow bit saved at interrupt entry, restored only by interrupt return
// - branch flag latches overflow, not-zero or bit-test result
// - conditional jumps and calls taken only with branch flag set
// - branch flag holds until next test; becomes 1 on branch fetch
// - branch flag saved at interrupt entry, restored only by interrupt return
// - fourteen-bit instruction counter holds current rom address
// - ten-bit stack pointer, next free slot, reset to 3FF
// - stack pointer moves down 4 per push, up 4 per pop
// - top four stack pointer bits fixed at 1111, sixteen levels
// - clearing stack reinit bit reloads stack pointer to reset value
// - reset acts while high; system holds it two instruction cycles
// - reset sets instruction counter to zero and branch flag to 1
// - reset clears interrupt enable and request, sets interrupt mask
// - reset sets port latches to 1, clears all direction bits
// - reset clears pin function selects a, b, c bits 3,1,0 and edge selects
// - reset clears every timer mode register
`timescale 1ns/1ps
module crf_top #(
  parameter int DPORT_BITS = 12
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  output logic                       err_o,
  // register state seen by the core
  output logic      [13:0]           icnt_o,
  output logic      [9:0]            sp_o,
  output logic      [9:0]            ram_addr_o,
  output logic      [DPORT_BITS-1:0] dport_sel_o,
  output logic                       branch_taken_o,
  output logic                       intr_enable_o,
  output logic                       intr_mask_o
);

  crf_pkg::crf_req_type   req;
  crf_pkg::crf_flags_type flags_now;
  crf_pkg::crf_flags_type saved_ff [crf_pkg::STACK_LVLS];

  logic [3:0]  acc_ff, opb_ff, col_ff, row_ff, auxx_ff, auxy_ff;
  logic [1:0]  page_ff;
  logic        ovf_ff, bcf_ff;
  logic [13:0] icnt_ff;
  logic [9:0]  sp_ff;
  logic        ack_ff, err_ff;
  logic [31:0] dat_ff;
  logic        ien_ff, ireq_ff, imsk_ff, sprinit_ff;
  logic [3:0]  pfsa_ff, pfsb_ff, pfsc_ff, edge1_ff, edge2_ff;
  logic [3:0]  tmra_ff, tmrb1_ff, tmrc1_ff, tmrd1_ff, tmrd2_ff;
  logic [1:0]  tmrb2_ff;
  logic [2:0]  tmrc2_ff;
  logic [7:0]  port_ofs;
  logic [3:0]  port_idx;
  logic [3:0]  latch_ff [crf_pkg::DIR_REGS];
  logic [3:0]  dir_ff   [crf_pkg::DIR_REGS];
  logic [15:0] ev;
  logic [3:0]  slot;
  logic [3:0]  slot_pop;
  logic        known;
  logic [31:0] nxt_dat;
  logic [31:0] wmask;

  function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
    is_ofs = (a == o);
  endfunction : is_ofs

  // per-lane write mask from sel
  always_comb begin
    wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  end

  // a request is taken only on the first cycle; ack drops the next cycle
  always_comb begin
    req.wr  = cyc_i && stb_i && we_i && !ack_ff && !err_ff && known;
    req.rd  = cyc_i && stb_i && !we_i && !ack_ff && !err_ff;
    req.adr = adr_i;
    req.dat = dat_i & wmask;
  end

  always_comb begin
    ev = req.wr && is_ofs(req.adr, crf_pkg::OFS_EVENT) ? req.dat[15:0]
                                                        : 16'h0000;
    flags_now.ovf = ovf_ff;
    flags_now.bcf = bcf_ff;
  end

  // slot index: sp steps by 4, so bits 5..2 name the level
  always_comb begin
    slot     = sp_ff[5:2];
    slot_pop = 4'(sp_ff[5:2] + 4'h1);
  end

  // port words do not start on a 64-byte boundary, so index from the base
  always_comb begin
    port_ofs = adr_i - crf_pkg::OFS_DRAM;
    port_idx = port_ofs[5:2];
  end

  always_comb begin
    known = 1'b1;
    unique case (adr_i)
      crf_pkg::OFS_ACC, crf_pkg::OFS_OPB, crf_pkg::OFS_PAGE,
      crf_pkg::OFS_COL, crf_pkg::OFS_ROW, crf_pkg::OFS_AUXX,
      crf_pkg::OFS_AUXY, crf_pkg::OFS_FLAGS, crf_pkg::OFS_ICNT,
      crf_pkg::OFS_SP, crf_pkg::OFS_EVENT, crf_pkg::OFS_INTCTL,
      crf_pkg::OFS_PFSA, crf_pkg::OFS_PFSB, crf_pkg::OFS_PFSC,
      crf_pkg::OFS_EDGE1, crf_pkg::OFS_EDGE2, crf_pkg::OFS_TMRA,
      crf_pkg::OFS_TMRB1, crf_pkg::OFS_TMRB2, crf_pkg::OFS_TMRC1,
      crf_pkg::OFS_TMRC2, crf_pkg::OFS_TMRD1, crf_pkg::OFS_TMRD2: known = 1'b1;
      // only the sixteen port words decode; anything past them is refused
      default: known = (adr_i >= crf_pkg::OFS_DRAM) && (adr_i[1:0] == 2'b00)
                       && (adr_i < 8'(crf_pkg::OFS_DRAM
                                     + 8'(crf_pkg::DIR_REGS * 4)));
    endcase
  end

  // working registers have no reset: software must load them
  always_ff @(posedge clk_i) begin
    if (req.wr) begin
      if (is_ofs(req.adr, crf_pkg::OFS_ACC))  acc_ff  <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_OPB))  opb_ff  <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_PAGE)) page_ff <= req.dat[1:0];
      if (is_ofs(req.adr, crf_pkg::OFS_COL))  col_ff  <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_ROW))  row_ff  <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_AUXX)) auxx_ff <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_AUXY)) auxy_ff <= req.dat[3:0];
    end
  end

  // no reset on purpose: overflow stays undefined until first written
  // overflow bit: alu overflow, set/clear/rotate ops, interrupt return
  always_ff @(posedge clk_i) begin
    if (ev[crf_pkg::EV_IRET] && !ev[crf_pkg::EV_SRET]) begin
      ovf_ff <= saved_ff[slot_pop].ovf;
    end else if (ev[crf_pkg::EV_SETC]) begin
      ovf_ff <= 1'b1;
    end else if (ev[crf_pkg::EV_CLRC]) begin
      ovf_ff <= 1'b0;
    end else if (ev[crf_pkg::EV_ROTC]) begin
      ovf_ff <= ev[crf_pkg::EV_ROTV];
    end else if (ev[crf_pkg::EV_ARITH]) begin
      ovf_ff <= ev[crf_pkg::EV_FLAG];
    end else if (req.wr && is_ofs(req.adr, crf_pkg::OFS_FLAGS)) begin
      ovf_ff <= req.dat[crf_pkg::FL_OVF];
    end
  end

  // branch flag: fetch of a branch forces 1, a test latches its result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcf_ff <= 1'b1;
    end else if (ev[crf_pkg::EV_BRFET]) begin
      bcf_ff <= 1'b1;
    end else if (ev[crf_pkg::EV_IRET]) begin
      bcf_ff <= saved_ff[slot_pop].bcf;
    end else if (ev[crf_pkg::EV_RESV]) begin
      bcf_ff <= ev[crf_pkg::EV_FLAG];
    end
  end

  // flag save on interrupt entry; subroutine return leaves flags alone
  always_ff @(posedge clk_i) begin
    if (ev[crf_pkg::EV_IENTRY]) begin
      saved_ff[slot] <= flags_now;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      icnt_ff <= crf_pkg::ICNT_RST;
    end else if (req.wr && is_ofs(req.adr, crf_pkg::OFS_ICNT)) begin
      icnt_ff <= req.dat[13:0];
    end
  end

  // a seventeenth push wraps onto level 15, the first one used; software must not nest deeper
  // stack pointer: one level per push or pop, top bits pinned
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_ff <= crf_pkg::SP_RST;
    end else if (req.wr && is_ofs(req.adr, crf_pkg::OFS_INTCTL)
                 && sprinit_ff && !req.dat[3]) begin
      sp_ff <= crf_pkg::SP_RST;
    end else if (ev[crf_pkg::EV_SPINIT]) begin
      sp_ff <= crf_pkg::SP_RST;
    end else if (ev[crf_pkg::EV_PUSH] || ev[crf_pkg::EV_IENTRY]) begin
      sp_ff <= {crf_pkg::SP_TOP, 6'(sp_ff[5:0] - 6'(crf_pkg::SP_STEP))};
    end else if (ev[crf_pkg::EV_POP] || ev[crf_pkg::EV_IRET]
                 || ev[crf_pkg::EV_SRET]) begin
      sp_ff <= {crf_pkg::SP_TOP, 6'(sp_ff[5:0] + 6'(crf_pkg::SP_STEP))};
    end
  end

  // interrupt control: bit0 enable, bit1 request, bit2 mask, bit3 reinit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ien_ff     <= 1'b0;
      ireq_ff    <= 1'b0;
      imsk_ff    <= 1'b1;
      sprinit_ff <= 1'b0;
    end else if (req.wr && is_ofs(req.adr, crf_pkg::OFS_INTCTL)) begin
      ien_ff     <= req.dat[0];
      ireq_ff    <= req.dat[1];
      imsk_ff    <= req.dat[2];
      sprinit_ff <= req.dat[3];
    end
  end

  // peripheral mode registers, all cleared by reset
  // pfsc bit 2 is cleared too: it has no reset duty, a known value is safer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pfsa_ff  <= crf_pkg::NIB_ZERO;
      pfsb_ff  <= crf_pkg::NIB_ZERO;
      pfsc_ff  <= crf_pkg::NIB_ZERO;
      edge1_ff <= crf_pkg::NIB_ZERO;
      edge2_ff <= crf_pkg::NIB_ZERO;
      tmra_ff  <= crf_pkg::NIB_ZERO;
      tmrb1_ff <= crf_pkg::NIB_ZERO;
      tmrb2_ff <= 2'b00;
      tmrc1_ff <= crf_pkg::NIB_ZERO;
      tmrc2_ff <= 3'b000;
      tmrd1_ff <= crf_pkg::NIB_ZERO;
      tmrd2_ff <= crf_pkg::NIB_ZERO;
    end else if (req.wr) begin
      if (is_ofs(req.adr, crf_pkg::OFS_PFSA))  pfsa_ff  <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_PFSB))  pfsb_ff  <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_PFSC))  pfsc_ff  <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_EDGE1)) edge1_ff <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_EDGE2)) edge2_ff <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_TMRA))  tmra_ff  <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_TMRB1)) tmrb1_ff <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_TMRB2)) tmrb2_ff <= req.dat[1:0];
      if (is_ofs(req.adr, crf_pkg::OFS_TMRC1)) tmrc1_ff <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_TMRC2)) tmrc2_ff <= req.dat[2:0];
      if (is_ofs(req.adr, crf_pkg::OFS_TMRD1)) tmrd1_ff <= req.dat[3:0];
      if (is_ofs(req.adr, crf_pkg::OFS_TMRD2)) tmrd2_ff <= req.dat[3:0];
    end
  end

  // port latch / direction pairs: word n holds latch[3:0], dir[7:4]
  // words past the sixteenth never land here: the decode refuses them
  genvar gi;
  generate
    for (gi = 0; gi < crf_pkg::DIR_REGS; gi++) begin : g_port
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          latch_ff[gi] <= crf_pkg::NIB_ONES;
          dir_ff[gi]   <= crf_pkg::NIB_ZERO;
        end else if (req.wr && is_ofs(req.adr,
                     8'(crf_pkg::OFS_DRAM + 8'(gi * 4)))) begin
          latch_ff[gi] <= req.dat[3:0];
          dir_ff[gi]   <= req.dat[7:4];
        end
      end
    end
  endgenerate

  // read mux; pfsc bit 2 is cleared by reset with the rest and reads as stored
  always_comb begin
    nxt_dat = 32'h0000_0000;
    unique case (adr_i)
      crf_pkg::OFS_ACC:    nxt_dat[3:0] = acc_ff;
      crf_pkg::OFS_OPB:    nxt_dat[3:0] = opb_ff;
      crf_pkg::OFS_PAGE:   nxt_dat[1:0] = page_ff;
      crf_pkg::OFS_COL:    nxt_dat[3:0] = col_ff;
      crf_pkg::OFS_ROW:    nxt_dat[3:0] = row_ff;
      crf_pkg::OFS_AUXX:   nxt_dat[3:0] = auxx_ff;
      crf_pkg::OFS_AUXY:   nxt_dat[3:0] = auxy_ff;
      crf_pkg::OFS_FLAGS:  nxt_dat[1:0] = {bcf_ff, ovf_ff};
      crf_pkg::OFS_ICNT:   nxt_dat[13:0] = icnt_ff;
      crf_pkg::OFS_SP:     nxt_dat[9:0] = sp_ff;
      crf_pkg::OFS_INTCTL: nxt_dat[3:0] = {sprinit_ff, imsk_ff, ireq_ff,
                                           ien_ff};
      crf_pkg::OFS_PFSA:   nxt_dat[3:0] = pfsa_ff;
      crf_pkg::OFS_PFSB:   nxt_dat[3:0] = pfsb_ff;
      crf_pkg::OFS_PFSC:   nxt_dat[3:0] = pfsc_ff;
      crf_pkg::OFS_EDGE1:  nxt_dat[3:0] = edge1_ff;
      crf_pkg::OFS_EDGE2:  nxt_dat[3:0] = edge2_ff;
      crf_pkg::OFS_TMRA:   nxt_dat[3:0] = tmra_ff;
      crf_pkg::OFS_TMRB1:  nxt_dat[3:0] = tmrb1_ff;
      crf_pkg::OFS_TMRB2:  nxt_dat[1:0] = tmrb2_ff;
      crf_pkg::OFS_TMRC1:  nxt_dat[3:0] = tmrc1_ff;
      crf_pkg::OFS_TMRC2:  nxt_dat[2:0] = tmrc2_ff;
      crf_pkg::OFS_TMRD1:  nxt_dat[3:0] = tmrd1_ff;
      crf_pkg::OFS_TMRD2:  nxt_dat[3:0] = tmrd2_ff;
      default: begin
        if (known && adr_i >= crf_pkg::OFS_DRAM) begin
          nxt_dat[7:0] = {dir_ff[port_idx], latch_ff[port_idx]};
        end
      end
    endcase
  end

  // one wait-free answer: ack or err the cycle after the request
  // ack_ff in the take term keeps a held request from being taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= cyc_i && stb_i && !ack_ff && !err_ff && known;
      err_ff <= cyc_i && stb_i && !ack_ff && !err_ff && !known;
      if (req.rd) dat_ff <= nxt_dat;
    end
  end

  assign dat_o          = dat_ff;
  assign ack_o          = ack_ff;
  assign err_o          = err_ff;
  assign icnt_o         = icnt_ff;
  assign sp_o           = sp_ff;
  assign ram_addr_o     = {page_ff, row_ff, col_ff};
  assign dport_sel_o    = DPORT_BITS'(1) << row_ff;
  assign branch_taken_o = bcf_ff;
  assign intr_enable_o  = ien_ff;
  assign intr_mask_o    = imsk_ff;
  // reset is held by the system for two instruction cycles

endmodule : crf_top
